// *** inc/clock_output_divider_consts.vh ***
// Constants shared by the clock output divider and its channels.
// Assumes inclusion by bare name from files that use these macros.
`ifndef CLOCK_OUTPUT_DIVIDER_CONSTS_VH
`define CLOCK_OUTPUT_DIVIDER_CONSTS_VH

// Number of clock outputs, each with its own divider
`define DIV_OUTPUTS 5
// Register map: even addresses from first to last
`define DIV_ADDR_FIRST 8'h4A
`define DIV_ADDR_LAST 8'h52
`define DIV_ADDR_STEP 8'h02
// Marker for an address outside the divider map
`define DIV_INDEX_NONE 4'hF
// Field layout of each divider register
`define OFF_COUNT_MSB 7
`define OFF_COUNT_LSB 4
`define ON_COUNT_MSB 3
`define ON_COUNT_LSB 0
`define COUNT_W 4
// Reset value of each divider register (divide by 2, half duty)
`define DIV_REG_RESET 8'h00
`define COUNT_ZERO 4'h0
// Value read back from an unmapped address
`define RD_UNMAPPED 8'h00

`endif

// *** verilog/divider_channel.v ***
// One integer divider channel: high phase then low phase per period.
// Assumes counts are stable register outputs and reset is synchronised.
`timescale 1ns/1ps
`include "clock_output_divider_consts.vh"

module divider_channel (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_hold,
  input wire [3:0] i_on_count,
  input wire [3:0] i_off_count,
  output reg o_div,
  output reg o_period_start,
  output wire [7:0] o_live_counts
);

  reg [3:0] cnt;
  reg [3:0] live_on;
  reg [3:0] live_off;
  reg in_high;

  assign o_live_counts = {live_off, live_on};

  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  // Counts are latched only at the period boundary, so a register
  // write mid-period never shortens the pulse in flight.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= `COUNT_ZERO;
      live_on <= `COUNT_ZERO;
      live_off <= `COUNT_ZERO;
      in_high <= 1'b0;
      o_div <= 1'b0;
      o_period_start <= 1'b0;
    end
    else if (i_hold)
    begin
      // Held off while bypassed; restart cleanly at a period edge
      cnt <= `COUNT_ZERO;
      in_high <= 1'b0;
      o_div <= 1'b0;
      o_period_start <= 1'b0;
    end
    else if (cnt != `COUNT_ZERO)
    begin
      cnt <= cnt - 4'h1;
      o_period_start <= 1'b0;
    end
    else if (in_high)
    begin
      // High lasted on_count + 1 cycles; now low for off_count + 1
      in_high <= 1'b0;
      o_div <= 1'b0;
      cnt <= live_off;
      o_period_start <= 1'b0;
    end
    else
    begin
      // Period boundary: reload both counts and go high
      live_on <= i_on_count;
      live_off <= i_off_count;
      cnt <= i_on_count;
      in_high <= 1'b1;
      o_div <= 1'b1;
      o_period_start <= 1'b1;
    end
  end

endmodule

// *** verilog/clock_output_divider.v ***
// Five programmable clock output dividers with their count registers.
// Assumes the serial control port drives the register write/read strobes
// synchronously to i_clk, which is the selected fast input clock.
`timescale 1ns/1ps
`include "clock_output_divider_consts.vh"

module clock_output_divider (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire [4:0] i_bypass,
  output reg [7:0] o_rd_data,
  output reg o_rd_valid,
  output wire [4:0] o_clk_out,
  output wire [4:0] o_period_start,
  output wire [39:0] o_live_counts
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_meta_n;
  reg rst_n;

  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Maps an address to a divider index, or the none marker when the
  // address is odd or outside the divider range.
  function [3:0] reg_index;
    input [7:0] addr;
    reg [7:0] offset;
    begin
      offset = addr - `DIV_ADDR_FIRST;
      if ((addr < `DIV_ADDR_FIRST) || (addr > `DIV_ADDR_LAST))
      begin
        reg_index = `DIV_INDEX_NONE;
      end
      else if (offset[0] != 1'b0)
      begin
        reg_index = `DIV_INDEX_NONE;
      end
      else
      begin
        reg_index = offset[4:1];
      end
    end
  endfunction

  // Turns a divider index into a one-hot select, one bit per output.
  // The none marker matches no bit, so odd and out-of-range addresses
  // reach no register at all.
  function [`DIV_OUTPUTS-1:0] index_hit;
    input [3:0] index;
    integer k;
    begin
      index_hit = {`DIV_OUTPUTS{1'b0}};
      for (k = 0; k < `DIV_OUTPUTS; k = k + 1)
      begin
        if (index == k[3:0])
        begin
          index_hit[k] = 1'b1;
        end
      end
    end
  endfunction

  // Picks the stored byte of the output that the select names; an
  // empty select reads as the unmapped value, never a neighbour.
  function [7:0] pick_count;
    input [`DIV_OUTPUTS*8-1:0] flat;
    input [`DIV_OUTPUTS-1:0] hit;
    integer k;
    begin
      pick_count = `RD_UNMAPPED;
      for (k = 0; k < `DIV_OUTPUTS; k = k + 1)
      begin
        if (hit[k])
        begin
          pick_count = flat[k * 8 +: 8];
        end
      end
    end
  endfunction

  wire [3:0] wr_index;
  wire [3:0] rd_index;
  wire [`DIV_OUTPUTS-1:0] wr_hit;
  wire [`DIV_OUTPUTS-1:0] rd_hit;

  assign wr_index = reg_index(i_addr);
  assign rd_index = reg_index(i_addr);
  // A write strobe that hits nothing is simply dropped; a read still answers
  assign wr_hit = index_hit(wr_index) & {`DIV_OUTPUTS{i_wr_en}};
  assign rd_hit = index_hit(rd_index);

  // ----------------------------------------
  // Divider count registers
  // ----------------------------------------
  wire [39:0] reg_flat;
  wire [4:0] div_q;

  genvar g;
  generate
    for (g = 0; g < `DIV_OUTPUTS; g = g + 1)
    begin : g_out
      reg [7:0] counts;
      wire bypassed;
      wire [`COUNT_W-1:0] on_count;
      wire [`COUNT_W-1:0] off_count;

      // Every 4-bit value is legal, so the write stores all eight bits
      always @(posedge i_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          counts <= `DIV_REG_RESET;
        end
        else if (wr_hit[g])
        begin
          counts <= i_wr_data;
        end
      end

      assign reg_flat[g * 8 +: 8] = counts;
      assign on_count = counts[`ON_COUNT_MSB:`ON_COUNT_LSB];
      assign off_count = counts[`OFF_COUNT_MSB:`OFF_COUNT_LSB];
      assign bypassed = i_bypass[g];

      divider_channel u_chan (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_hold(bypassed),
        .i_on_count(on_count),
        .i_off_count(off_count),
        .o_div(div_q[g]),
        .o_period_start(o_period_start[g]),
        .o_live_counts(o_live_counts[g * 8 +: 8])
      );

    end
  endgenerate

  // ----------------------------------------
  // Output select
  // ----------------------------------------
  // Bypass passes the input clock straight through; the divider
  // is held idle meanwhile. The mux is glitch-prone on the
  // switch itself, so change bypass only while the output is unused.
  generate
    for (g = 0; g < `DIV_OUTPUTS; g = g + 1)
    begin : g_sel
      assign o_clk_out[g] = i_bypass[g] ? i_clk : div_q[g];
    end
  endgenerate

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  // Reads return the stored value; the counts in use until the next
  // period edge are visible on o_live_counts.
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rd_data <= `RD_UNMAPPED;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en)
      begin
        o_rd_data <= pick_count(reg_flat, rd_hit);
      end
    end
  end

endmodule

// *** bench/clock_output_divider_properties.sv ***
// Checker for clock_output_divider on its top ports.
// Assumes output 0 stays unbypassed while it runs.
`timescale 1ns/1ps
module clock_output_divider_properties (
  input logic i_clk,
  input logic i_arst_n,
  input logic i_rd_en,
  input logic [7:0] i_addr,
  input logic [4:0] i_bypass,
  input logic [7:0] o_rd_data,
  input logic o_rd_valid,
  input logic [4:0] o_clk_out,
  input logic [4:0] o_period_start,
  input logic [39:0] o_live_counts
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n || i_bypass[0]);
  // Age of 32 or more marks that no period has begun yet
  logic [5:0] age;
  wire [5:0] pos = o_period_start[0] ? 6'h00 : age;
  wire [5:0] last = {2'h0, o_live_counts[3:0]} + {2'h0, o_live_counts[7:4]} + 6'h01;
  wire unmapped = i_addr < 8'h4A || i_addr > 8'h52 || i_addr[0];
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
      age <= 6'h20;
    else
      age <= pos + 6'h01;
  sequence half_low;
    !o_clk_out[0] ##1 o_period_start[0];
  endsequence
  a_read_answer: assert property (o_rd_valid == $past(i_rd_en))
    else $error("read valid misplaced");
  a_unmapped_zero: assert property (i_rd_en && unmapped |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_data_holds: assert property (!o_rd_valid |-> $stable(o_rd_data))
    else $error("read data moved");
  a_start_high: assert property ((o_period_start & ~o_clk_out & ~i_bypass) == 5'h00)
    else $error("period starts low");
  a_high_phase: assert property (!pos[5] |-> o_clk_out[0] == (pos <= o_live_counts[3:0]))
    else $error("high phase length wrong");
  a_period_len: assert property (pos == last |=> o_period_start[0])
    else $error("period length wrong");
  a_live_hold: assert property (!o_period_start[0] |-> $stable(o_live_counts[7:0]))
    else $error("counts changed mid period");
  a_half_rate: assert property (o_period_start[0] && o_live_counts[7:0] == 8'h00 |=> half_low)
    else $error("divide by two not symmetric");
endmodule
bind clock_output_divider clock_output_divider_properties u_props (.*);

// *** bench/tb_clock_output_divider.sv ***
// Bench for clock_output_divider: table of count settings, then edge cases.
// Assumes the design and its constants header are compiled first.
`timescale 1ns/1ps
module tb_clock_output_divider;
  typedef struct packed {logic [2:0] ch; logic [7:0] cfg, hi, lo;} row_t;
  row_t rows[9] = '{'{3'h0, 8'h33, 8'h04, 8'h04}, '{3'h1, 8'h42, 8'h03, 8'h05},
    '{3'h2, 8'h00, 8'h01, 8'h01}, '{3'h3, 8'h11, 8'h02, 8'h02}, '{3'h4, 8'h02, 8'h03, 8'h01},
    '{3'h0, 8'h20, 8'h01, 8'h03}, '{3'h1, 8'hFF, 8'h10, 8'h10}, '{3'h2, 8'h0F, 8'h10, 8'h01},
    '{3'h3, 8'hF0, 8'h01, 8'h10}};
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0, o_rd_valid;
  logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, o_rd_data, h, l;
  logic [4:0] i_bypass = 5'h00, o_clk_out, o_period_start;
  logic [39:0] o_live_counts;
  int bad_count = 0, comparisons = 0;
  always #10 i_clk = ~i_clk;
  clock_output_divider u_dut (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= v;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    @(negedge i_clk);
    chk(o_rd_data, e);
    chk({7'h00, o_rd_valid}, 8'h01);
  endtask
  // Measures the first whole period that starts after the call
  task automatic meas(input logic [2:0] c);
    int n;
    n = 0;
    h = 8'h00;
    l = 8'h00;
    do
    begin
      @(negedge i_clk);
      n++;
    end while (o_period_start[c] !== 1'b1 && n < 99);
    while (o_clk_out[c] === 1'b1 && h < 8'h28)
    begin
      h++;
      @(negedge i_clk);
    end
    while (o_period_start[c] !== 1'b1 && l < 8'h28)
    begin
      l++;
      @(negedge i_clk);
    end
  endtask
  task final_report;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    bad_count++;
    final_report;
  end
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int c = 0; c < 5; c++)
      rd(8'h4A + 8'(2 * c), 8'h00);
    foreach (rows[i])
    begin
      wr(8'h4A + {4'h0, rows[i].ch, 1'b0}, rows[i].cfg);
      rd(8'h4A + {4'h0, rows[i].ch, 1'b0}, rows[i].cfg);
      meas(rows[i].ch);
      chk(h, rows[i].hi);
      chk(l, rows[i].lo);
      chk(o_live_counts[rows[i].ch * 8 +: 8], rows[i].cfg);
    end
    // Last row left output 3 at a period start: a write now must wait
    wr(8'h50, 8'h11);
    @(negedge i_clk);
    chk(o_live_counts[31:24], 8'hF0);
    meas(3'h3);
    chk(h, 8'h02);
    chk(l, 8'h02);
    wr(8'h4B, 8'hAA);
    rd(8'h4B, 8'h00);
    rd(8'h54, 8'h00);
    rd(8'h4A, 8'h20);
    @(posedge i_clk);
    i_bypass <= 5'h10;
    @(posedge i_clk);
    #5 chk({7'h00, o_clk_out[4]}, 8'h01);
    @(negedge i_clk);
    #5 chk({7'h00, o_clk_out[4]}, 8'h00);
    @(posedge i_clk);
    i_bypass <= 5'h00;
    meas(3'h4);
    chk(h, 8'h03);
    chk(l, 8'h01);
    // Reset in mid-run: outputs clear at once, registers return to 00
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    @(negedge i_clk);
    chk({3'h0, o_clk_out}, 8'h00);
    chk(o_rd_data, 8'h00);
    chk(o_live_counts[7:0], 8'h00);
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(8'h50, 8'h00);
    meas(3'h0);
    chk(h, 8'h01);
    chk(l, 8'h01);
    final_report;
  end
endmodule
